/* include/psb_pkg.sv */
// Package: constants, carriers and state type of the strap and basic control block
package psb_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [4:0]  REG_BASIC_CONTROL  = 5'h00;
  localparam logic [4:0]  REG_BASIC_STATUS   = 5'h01;
  localparam logic [4:0]  REG_MMD_CTRL       = 5'h0D;
  localparam logic [4:0]  REG_MMD_DATA       = 5'h0E;
  localparam logic [15:0] EXT_MULTI_IND_CTRL = 16'h0025;
  localparam logic [15:0] EXT_IND_CONFIG     = 16'h0460;
  localparam logic [4:0]  MMD_VENDOR_DEVAD   = 5'h1F;

  // ==========================================================
  // Basic control bit positions
  localparam int BC_RESET      = 15;
  localparam int BC_LOOPBACK   = 14;
  localparam int BC_SPEED100   = 13;
  localparam int BC_AN_ENABLE  = 12;
  localparam int BC_POWER_DOWN = 11;
  localparam int BC_ISOLATE    = 10;
  localparam int BC_AN_RESTART = 9;
  localparam int BC_FULL_DUP   = 8;
  localparam int BC_COL_TEST   = 7;

  // ==========================================================
  // Basic status layout and reset values
  localparam int              BS_AN_COMPLETE   = 5;
  localparam int              BS_REMOTE_FAULT  = 4;
  localparam int              BS_LINK          = 2;
  localparam logic [15:0]     BASIC_STATUS_CAP = 16'h7840;
  localparam logic [15:0]     MULTI_IND_RESET  = 16'h0000;
  localparam logic [15:0]     IND_CONFIG_RESET = 16'h0000;
  localparam logic [4:0]      PHY_ADDR_DEFAULT = 5'h01;
  localparam logic [1:0]      MULTI_FUNCTION_INDICATOR_TO_FIRST    = 2'h0;
  localparam logic [1:0]      MULTI_FUNCTION_INDICATOR_TO_COL      = 2'h1;

  // ==========================================================
  // Cycle counts
  localparam logic [2:0] SOFT_RESET_CYCLES  = 3'h4;
  localparam logic [1:0] STRAP_SAMPLE_CYCLE = 2'h2;
  localparam logic [4:0] MDIO_HDR_LAST      = 5'h0C;
  localparam logic [4:0] MDIO_DATA_LAST     = 5'h0F;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {MAC_MII, MAC_RMII, MAC_RGMII, MAC_RESERVED} psb_mac_mode_t;
  typedef enum logic [1:0] {MD_IDLE, MD_HDR, MD_TA, MD_DATA} psb_mdio_st_t;

  typedef struct packed {
    logic       rgmiiEn;
    logic       rmiiEn;
    logic       refClockFifty;
    logic [4:0] phyAddr;
    logic [4:0] phyAddrPulled;
    logic       firstInd;
    logic       secondInd;
    logic       colPin;
    logic       anEnable;
    logic       speed100;
    logic       fullDuplex;
  } psb_straps_t;

  typedef struct packed {
    logic       en;
    logic [3:0] data;
  } psb_mii_t;

  typedef struct packed {
    psb_straps_t straps;
    logic        mdc;
    logic        mdio;
    logic        pdN;
  } psb_pins_t;

  typedef struct packed {
    psb_pins_t     syncA;
    psb_pins_t     syncB;
    psb_straps_t   strap;
    logic [1:0]    strapCnt;
    logic          strapDone;
    logic [15:0]   basicCtrl;
    logic [2:0]    softCnt;
    logic          linkLat;
    logic          faultLat;
    logic          anDoneEvt;
    logic [15:0]   mmdCtrl;
    logic [15:0]   extAddr;
    logic [15:0]   multiInd;
    logic [15:0]   indCfg;
    psb_mdio_st_t  mdState;
    logic          mdcPrev;
    logic          lastOne;
    logic [4:0]    mdCnt;
    logic [12:0]   hdrShift;
    logic          isRead;
    logic [4:0]    regAddr;
    logic [15:0]   dataShift;
    logic          mdioOut;
    logic          mdioOe;
    psb_mii_t      rxMii;
    logic          collision;
    logic          firstIndOut;
    logic          firstIndOe;
    logic          secondIndOut;
    logic          secondIndOe;
    logic          colPinOut;
    logic          colPinOe;
    psb_mac_mode_t macMode;
    logic          refClockFifty;
    logic          powerDown;
    logic          isolate;
    logic          anEnable;
    logic          anRestart;
    logic          speed100;
    logic          fullDuplex;
    logic          pcsReset;
  } psb_state_t;

endpackage

/* hdl/psb_strap_ctrl.sv */
// Strap capture, indicator routing, basic control register and management slave
`timescale 1ns/100ps
// Overview of operation
// - RMII strap alone picks RMII; clock strap chooses 25 or 50 MHz reference.
// - RGMII strap with clock strap low picks RGMII at 25 MHz; else reserved.
// - Multi-function indicator drives only one pin, chosen by its control bits 1:0.
// - Indicator pin functions come from configuration and multi-indicator registers.
// - Indicator pin strapped low is driven active high afterwards.
// - Indicator pin strapped high is driven active low afterwards.
// - A 5-bit management address is latched from straps at hardware reset.
// - Address defaults to 1 when no pull resistors change the straps.
// - Latched-high holds set, latched-low holds clear until read; clear-on-read clears.
// - Event status bits follow the event and drop when it ends.
// - Strap-type fields load reset values from sampled strap pins.
// - Control bit 15 resets the basic control register then self-clears; MMD and vendor registers kept.
// - Software reset never resamples straps; only hardware reset does.
// - Control bit 14 loops transmit data back onto the receive path.
// - Control bit 13 selects 100 or 10 Mb/s while negotiation is off.
// - Control bit 12 enables negotiation; when off bits 8 and 13 fix mode.
// - Power-down is bit 11 OR the pin; the pin sets the bit.
// - Power-down keeps programmed registers but resets state and status.
// - Control bit 10 isolates the port from the MII.
// - Control bit 9 restarts negotiation, self-clears, ignored when negotiation off.
// - Control bit 8 selects full or half duplex while negotiation is off.
// - Collision test raises collision after transmit enable and drops it after.
module psb_strap_ctrl
  import psb_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire psb_straps_t strapPins,
  input  wire logic        mdc,
  input  wire logic        mdioIn,
  output logic             mdioOut,
  output logic             mdioOe,
  input  wire logic        irqPowerdownPinN,
  input  wire logic        linkUp,
  input  wire logic        remoteFault,
  input  wire logic        anComplete,
  input  wire logic        anSpeed100,
  input  wire logic        anFullDuplex,
  input  wire logic        activity,
  input  wire psb_mii_t    txMii,
  input  wire psb_mii_t    rxLine,
  output psb_mii_t         rxMii,
  output logic             collision,
  output logic             firstIndicatorOut,
  output logic             firstIndicatorOe,
  output logic             secondIndicatorOut,
  output logic             secondIndicatorOe,
  output logic             colPinOut,
  output logic             colPinOe,
  output psb_mac_mode_t    macMode,
  output logic             refClockFifty,
  output logic             powerDown,
  output logic             isolate,
  output logic             anEnable,
  output logic             anRestart,
  output logic             speed100,
  output logic             fullDuplex,
  output logic             pcsReset
);

  // ==========================================================
  // Reset release
  logic [1:0] rstSync;
  logic       rstN;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  assign rstN = rstSync[1];

  // ==========================================================
  // Helpers
  function automatic logic [15:0] bcDefaults(input psb_straps_t s);
    logic [15:0] v;
    v               = 16'h0000;
    v[BC_SPEED100]  = s.speed100;
    v[BC_AN_ENABLE] = s.anEnable;
    v[BC_FULL_DUP]  = s.fullDuplex;
    return v;
  endfunction

  function automatic logic indFunc(input logic [3:0] code, input logic lnk, input logic act,
                                   input logic spd, input logic dup, input logic col);
    logic v;
    v = 1'b0;
    case (code)
      4'h0:    v = lnk;
      4'h1:    v = act;
      4'h2:    v = lnk & ~act;
      4'h3:    v = spd;
      4'h4:    v = dup;
      4'h5:    v = col;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // ==========================================================
  // Next state
  psb_state_t st_r;
  psb_state_t st_nxt;

  always_comb begin
    logic        mdcRise;
    logic        mdcFall;
    logic        bitIn;
    logic [12:0] hdr;
    logic        hdrOk;
    logic        wrStb;
    logic [15:0] wrData;
    logic        rdStatus;
    logic [15:0] rdVal;
    logic [15:0] extVal;
    logic        extSel;
    logic        pinPd;
    logic        pd;
    logic        effSpd;
    logic        effDup;
    logic        multi_function_indicator;
    logic [15:0] bc;
    mdcRise  = 1'b0;
    mdcFall  = 1'b0;
    bitIn    = 1'b0;
    hdr      = 13'h0000;
    hdrOk    = 1'b0;
    wrStb    = 1'b0;
    wrData   = 16'h0000;
    rdStatus = 1'b0;
    rdVal    = 16'h0000;
    extVal   = 16'h0000;
    extSel   = 1'b0;
    pinPd    = 1'b0;
    pd       = 1'b0;
    effSpd   = 1'b0;
    effDup   = 1'b0;
    multi_function_indicator     = 1'b0;
    bc       = 16'h0000;
    st_nxt   = st_r;

    st_nxt.syncA = {strapPins, mdc, mdioIn, irqPowerdownPinN};
    st_nxt.syncB = st_r.syncA;

    // ==========================================================
    // Strap capture, once per hardware reset
    // straps hardware only
    if (!st_r.strapDone) begin
      st_nxt.strapCnt = st_r.strapCnt + 2'h1;
      // Wait out the synchroniser so the sample is the pin, not the reset value
      if (st_r.strapCnt == STRAP_SAMPLE_CYCLE) begin
        st_nxt.strapDone = 1'b1;
        st_nxt.strap     = st_r.syncB.straps;
        for (int i = 0; i < 5; i++) begin
          st_nxt.strap.phyAddr[i] = st_r.syncB.straps.phyAddrPulled[i] ?
                                    st_r.syncB.straps.phyAddr[i] : PHY_ADDR_DEFAULT[i];
        end
        st_nxt.basicCtrl = bcDefaults(st_r.syncB.straps);
      end
    end

    // ==========================================================
    // Management slave
    mdcRise         = st_r.syncB.mdc & ~st_r.mdcPrev;
    mdcFall         = ~st_r.syncB.mdc & st_r.mdcPrev;
    bitIn           = st_r.syncB.mdio;
    st_nxt.mdcPrev  = st_r.syncB.mdc;
    hdr             = {st_r.hdrShift[11:0], bitIn};
    extSel          = st_r.mmdCtrl[15:14] != 2'h0;

    if (st_r.extAddr == EXT_MULTI_IND_CTRL) begin
      extVal = st_r.multiInd;
    end else if (st_r.extAddr == EXT_IND_CONFIG) begin
      extVal = st_r.indCfg;
    end

    case (hdr[4:0])
      REG_BASIC_CONTROL: rdVal = st_r.basicCtrl;
      REG_BASIC_STATUS:  rdVal = BASIC_STATUS_CAP | {10'h000, st_r.anDoneEvt, st_r.faultLat,
                                                     1'b0, st_r.linkLat, 2'b00};
      REG_MMD_CTRL:      rdVal = st_r.mmdCtrl;
      REG_MMD_DATA:      rdVal = extSel ? extVal : st_r.extAddr;
      default:           rdVal = 16'h0000;
    endcase

    unique case (st_r.mdState)
      MD_IDLE: begin
        if (mdcFall) begin
          st_nxt.mdioOe  = 1'b0;
          st_nxt.mdioOut = 1'b0;
        end
        if (mdcRise) begin
          st_nxt.lastOne = bitIn;
          // Start bit pattern after any ones, so suppressed preamble also works
          if (!bitIn && st_r.lastOne && st_r.strapDone) begin
            st_nxt.mdState  = MD_HDR;
            st_nxt.mdCnt    = 5'h00;
            st_nxt.hdrShift = 13'h0000;
          end
        end
      end
      MD_HDR: begin
        if (mdcRise) begin
          st_nxt.hdrShift = hdr;
          st_nxt.mdCnt    = st_r.mdCnt + 5'h01;
          if (st_r.mdCnt == MDIO_HDR_LAST) begin
            hdrOk = hdr[12] && (hdr[11:10] == 2'b01 || hdr[11:10] == 2'b10) &&
                    hdr[9:5] == st_r.strap.phyAddr;
            st_nxt.mdCnt   = 5'h00;
            st_nxt.lastOne = 1'b0;
            st_nxt.mdState = hdrOk ? MD_TA : MD_IDLE;
            st_nxt.isRead  = hdr[11:10] == 2'b10;
            st_nxt.regAddr = hdr[4:0];
            if (hdrOk && hdr[11:10] == 2'b10) begin
              st_nxt.dataShift = rdVal;
              rdStatus = hdr[4:0] == REG_BASIC_STATUS;
            end
          end
        end
      end
      MD_TA: begin
        if (mdcFall && st_r.isRead && st_r.mdCnt == 5'h01) begin
          st_nxt.mdioOe  = 1'b1;
          st_nxt.mdioOut = 1'b0;
        end
        if (mdcRise) begin
          st_nxt.mdCnt   = (st_r.mdCnt == 5'h01) ? 5'h00 : 5'h01;
          st_nxt.mdState = (st_r.mdCnt == 5'h01) ? MD_DATA : MD_TA;
        end
      end
      MD_DATA: begin
        if (mdcFall && st_r.isRead) begin
          st_nxt.mdioOut   = st_r.dataShift[15];
          st_nxt.dataShift = {st_r.dataShift[14:0], 1'b0};
        end
        if (mdcRise) begin
          st_nxt.mdCnt = st_r.mdCnt + 5'h01;
          if (!st_r.isRead) begin
            st_nxt.dataShift = {st_r.dataShift[14:0], bitIn};
          end
          if (st_r.mdCnt == MDIO_DATA_LAST) begin
            st_nxt.mdState = MD_IDLE;
            wrStb          = !st_r.isRead;
            wrData         = {st_r.dataShift[14:0], bitIn};
          end
        end
      end
    endcase

    // ==========================================================
    // Register writes
    bc = st_nxt.basicCtrl;
    // self-clear after pulse, before a new write so a fresh request wins
    if (st_r.basicCtrl[BC_AN_RESTART] && st_r.anRestart) begin
      bc[BC_AN_RESTART] = 1'b0;
    end
    if (wrStb) begin
      case (st_r.regAddr)
        REG_BASIC_CONTROL: begin
          bc                = {wrData[15:7], 7'h00};
          bc[BC_AN_RESTART] = wrData[BC_AN_RESTART] & wrData[BC_AN_ENABLE];
        end
        REG_MMD_CTRL: st_nxt.mmdCtrl = wrData;
        REG_MMD_DATA: begin
          if (!extSel) begin
            st_nxt.extAddr = wrData;
          end else if (st_r.mmdCtrl[4:0] == MMD_VENDOR_DEVAD) begin
            if (st_r.extAddr == EXT_MULTI_IND_CTRL) begin
              st_nxt.multiInd = wrData;
            end else if (st_r.extAddr == EXT_IND_CONFIG) begin
              st_nxt.indCfg = wrData;
            end
          end
        end
        default: ;
      endcase
    end

    pinPd = ~st_r.syncB.pdN;
    if (pinPd && st_r.strapDone) begin
      bc[BC_POWER_DOWN] = 1'b1;
    end

    if (wrStb && st_r.regAddr == REG_BASIC_CONTROL && wrData[BC_RESET] && st_r.softCnt == 3'h0) begin
      st_nxt.softCnt = SOFT_RESET_CYCLES;
    end else if (st_r.softCnt != 3'h0) begin
      st_nxt.softCnt = st_r.softCnt - 3'h1;
      bc[BC_RESET]   = 1'b1;
      if (st_r.softCnt == 3'h1) begin
        // Vendor registers and latched straps stay as they are
        bc = bcDefaults(st_r.strap);
      end
    end
    st_nxt.basicCtrl = bc;

    // ==========================================================
    // Status latches
    pd = st_r.basicCtrl[BC_POWER_DOWN] | pinPd;
    if (pd || st_r.pcsReset) begin
      st_nxt.linkLat   = 1'b0;
      st_nxt.faultLat  = 1'b0;
      st_nxt.anDoneEvt = 1'b0;
    end else begin
      st_nxt.linkLat   = linkUp & (st_r.linkLat | rdStatus);
      st_nxt.faultLat  = remoteFault | (st_r.faultLat & ~rdStatus);
      st_nxt.anDoneEvt = anComplete;
    end

    // ==========================================================
    // Mode outputs
    // MAC interface mode decode (RGMII, RMII, MII or reserved)
    if (st_r.strap.rgmiiEn) begin
      st_nxt.macMode = st_r.strap.refClockFifty ? MAC_RESERVED : MAC_RGMII;
    end else if (st_r.strap.rmiiEn) begin
      st_nxt.macMode = MAC_RMII;
    end else begin
      st_nxt.macMode = st_r.strap.refClockFifty ? MAC_RESERVED : MAC_MII;
    end
    st_nxt.refClockFifty = st_r.strap.refClockFifty;

    effSpd = st_r.basicCtrl[BC_AN_ENABLE] ? anSpeed100 : st_r.basicCtrl[BC_SPEED100];
    effDup = st_r.basicCtrl[BC_AN_ENABLE] ? anFullDuplex : st_r.basicCtrl[BC_FULL_DUP];
    st_nxt.speed100   = effSpd;
    st_nxt.fullDuplex = effDup;
    st_nxt.anEnable   = st_r.basicCtrl[BC_AN_ENABLE] & ~pd;
    st_nxt.anRestart  = st_r.basicCtrl[BC_AN_RESTART] & st_r.basicCtrl[BC_AN_ENABLE] &
                        ~st_r.anRestart & ~pd;
    st_nxt.powerDown  = pd;
    st_nxt.isolate    = st_r.basicCtrl[BC_ISOLATE];
    st_nxt.pcsReset   = st_nxt.softCnt != 3'h0;

    // ==========================================================
    // Data path
    // isolate
    if (st_r.basicCtrl[BC_ISOLATE] || pd) begin
      st_nxt.rxMii     = '0;
      st_nxt.collision = 1'b0;
    end else begin
      st_nxt.rxMii     = st_r.basicCtrl[BC_LOOPBACK] ? txMii : rxLine;
      // collision test, one cycle behind transmit enable
      st_nxt.collision = st_r.basicCtrl[BC_COL_TEST] & txMii.en;
    end

    // ==========================================================
    // Indicators: pins stay released until their straps are sampled
    multi_function_indicator = indFunc(st_r.multiInd[7:4], linkUp, activity, effSpd, effDup, st_r.collision);
    st_nxt.firstIndOe  = st_r.strapDone;
    st_nxt.secondIndOe = st_r.strapDone;
    st_nxt.colPinOe    = st_r.strapDone & ~st_r.basicCtrl[BC_ISOLATE];
    if (st_r.multiInd[1:0] == MULTI_FUNCTION_INDICATOR_TO_FIRST) begin
      st_nxt.firstIndOut = multi_function_indicator ^ st_r.strap.firstInd;
    end else begin
      st_nxt.firstIndOut = indFunc(st_r.indCfg[3:0], linkUp, activity, effSpd, effDup,
                                   st_r.collision) ^ st_r.strap.firstInd;
    end
    st_nxt.secondIndOut = indFunc(st_r.indCfg[7:4], linkUp, activity, effSpd, effDup,
                                  st_r.collision) ^ st_r.strap.secondInd;
    st_nxt.colPinOut    = (st_r.multiInd[1:0] == MULTI_FUNCTION_INDICATOR_TO_COL) ?
                          (multi_function_indicator ^ st_r.strap.colPin) : st_r.collision;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      st_r           <= '0;
      st_r.multiInd  <= MULTI_IND_RESET;
      st_r.indCfg    <= IND_CONFIG_RESET;
      st_r.mdState   <= MD_IDLE;
      st_r.macMode   <= MAC_MII;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign mdioOut            = st_r.mdioOut;
  assign mdioOe             = st_r.mdioOe;
  assign rxMii              = st_r.rxMii;
  assign collision          = st_r.collision;
  assign firstIndicatorOut  = st_r.firstIndOut;
  assign firstIndicatorOe   = st_r.firstIndOe;
  assign secondIndicatorOut = st_r.secondIndOut;
  assign secondIndicatorOe  = st_r.secondIndOe;
  assign colPinOut          = st_r.colPinOut;
  assign colPinOe           = st_r.colPinOe;
  assign macMode            = st_r.macMode;
  assign refClockFifty      = st_r.refClockFifty;
  assign powerDown          = st_r.powerDown;
  assign isolate            = st_r.isolate;
  assign anEnable           = st_r.anEnable;
  assign anRestart          = st_r.anRestart;
  assign speed100           = st_r.speed100;
  assign fullDuplex         = st_r.fullDuplex;
  assign pcsReset           = st_r.pcsReset;

endmodule

/* tb/psb_props.sv */
// Checker for the strap and basic control block
`timescale 1ns/100ps
module psb_props
  import psb_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          nrst,
  input wire logic          irqPowerdownPinN,
  input wire psb_mii_t      rxMii,
  input wire logic          colPinOe,
  input wire logic          firstIndicatorOe,
  input wire psb_mac_mode_t macMode,
  input wire logic          refClockFifty,
  input wire logic          powerDown,
  input wire logic          isolate,
  input wire logic          anEnable,
  input wire logic          anRestart,
  input wire logic          pcsReset
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // ====================
  // Sequences
  sequence s_resetPulse;
    pcsReset [*4] ##1 !pcsReset;
  endsequence
  sequence s_pinLow;
    !irqPowerdownPinN [*6];
  endsequence
  // ====================
  // Properties
  property p_softPulse; $rose(pcsReset) |-> s_resetPulse; endproperty
  a_softPulse: assert property (p_softPulse) else $error("soft reset length");
  property p_strapKeep; pcsReset |-> $stable(macMode) && $stable(refClockFifty); endproperty
  a_strapKeep: assert property (p_strapKeep) else $error("straps resampled");
  property p_refClk; macMode inside {MAC_MII, MAC_RGMII} |-> !refClockFifty; endproperty
  a_refClk: assert property (p_refClk) else $error("reference clock mode");
  property p_restart; anRestart |-> anEnable ##1 !anRestart; endproperty
  a_restart: assert property (p_restart) else $error("restart pulse");
  property p_pinFall; $fell(irqPowerdownPinN) |-> ##[2:6] powerDown; endproperty
  a_pinFall: assert property (p_pinFall) else $error("pin power-down late");
  property p_pinHold; s_pinLow |-> powerDown; endproperty
  a_pinHold: assert property (p_pinHold) else $error("power-down dropped");
  property p_pdRx; powerDown [*2] |-> rxMii == '0; endproperty
  a_pdRx: assert property (p_pdRx) else $error("receive active in power-down");
  property p_isoCol; isolate [*2] |-> !colPinOe; endproperty
  a_isoCol: assert property (p_isoCol) else $error("collision pin driven");
  property p_indKeep; firstIndicatorOe |=> firstIndicatorOe; endproperty
  a_indKeep: assert property (p_indKeep) else $error("indicator drive lost");
endmodule
bind psb_strap_ctrl psb_props i_psb_props (.clk_sys, .nrst, .irqPowerdownPinN, .rxMii,
  .colPinOe, .firstIndicatorOe, .macMode, .refClockFifty, .powerDown, .isolate,
  .anEnable, .anRestart, .pcsReset);

/* tb/psb_mdio_master.sv */
// Management bus master model for the strap and basic control bench
`timescale 1ns/100ps
module psb_mdio_master (
  input  wire logic clk_sys,
  input  wire logic mdioOut,
  input  wire logic mdioOe,
  output logic      mdc,
  output logic      mdioIn
);
  logic        mOe = 1'h0;
  logic        mOut = 1'h1;
  logic [15:0] rdData = '0;
  event        rdDone;
  initial mdc = 1'h0;
  // Pull-up holds the line high when nobody drives it
  assign mdioIn = (mdioOe === 1'h1) ? mdioOut : (mOe ? mOut : 1'h1);
  // ====================
  // One frame: short preamble then 32 frame bits, clock stops after
  task automatic frame(input logic [31:0] f, input logic rd);
    logic [39:0] b;
    b = {8'hFF, f};
    for (int i = 39; i >= 0; i--) begin
      @(posedge clk_sys);
      mdc  <= 1'h0;
      mOut <= b[i];
      mOe  <= !(rd && (i < 18));
      repeat (5) @(posedge clk_sys);
      mdc    <= 1'h1;
      rdData <= {rdData[14:0], mdioIn};
      repeat (5) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    mdc <= 1'h0;
    mOe <= 1'h0;
    repeat (6) @(posedge clk_sys);
    if (rd) -> rdDone;
  endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the strap and basic control block
`timescale 1ns/100ps
module tb
  import psb_pkg::*;
;
  logic          clk_sys = 1'h0;
  logic          nrst = 1'h0;
  logic          irqPowerdownPinN = 1'h1;
  logic          linkUp = 1'h0;
  logic          remoteFault = 1'h0, anComplete = 1'h0, anSpeed100 = 1'h0;
  logic          anFullDuplex = 1'h0, activity = 1'h0;
  logic          mdc, mdioIn, mdioOut, mdioOe, collision, refClockFifty, powerDown;
  logic          firstIndicatorOut, firstIndicatorOe, secondIndicatorOut, secondIndicatorOe;
  logic          colPinOut, colPinOe, isolate, anEnable, anRestart, speed100, fullDuplex;
  logic          pcsReset;
  psb_straps_t   strapPins = '0;
  psb_straps_t   s;
  psb_mii_t      txMii = '0, rxLine = '0, rxMii;
  psb_mac_mode_t macMode;
  logic [4:0]    phyA;
  logic [15:0]   rnd;
  logic [15:0]   expQ[$];
  int            n_errors = 0, check_count = 0;

  always #25 clk_sys = ~clk_sys;

  psb_strap_ctrl i_psb_strap_ctrl (.clk_sys, .nrst, .strapPins, .mdc, .mdioIn, .mdioOut,
    .mdioOe, .irqPowerdownPinN, .linkUp, .remoteFault, .anComplete, .anSpeed100,
    .anFullDuplex, .activity, .txMii, .rxLine, .rxMii, .collision, .firstIndicatorOut,
    .firstIndicatorOe, .secondIndicatorOut, .secondIndicatorOe, .colPinOut, .colPinOe,
    .macMode, .refClockFifty, .powerDown, .isolate, .anEnable, .anRestart, .speed100,
    .fullDuplex, .pcsReset);
  psb_mdio_master i_psb_mdio_master (.clk_sys, .mdioOut, .mdioOe, .mdc, .mdioIn);

  // ====================
  // Tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic hwrst();
    @(posedge clk_sys);
    nrst      <= 1'h0;
    strapPins <= s;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'h1;
    repeat (20) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [4:0] r, input logic [15:0] d);
    i_psb_mdio_master.frame({4'h5, phyA, r, 2'h2, d}, 1'h0);
  endtask
  task automatic rd(input logic [4:0] r, input logic [15:0] e);
    expQ.push_back(e);
    i_psb_mdio_master.frame({4'h6, phyA, r, 18'h0_0000}, 1'h1);
  endtask
  task automatic ext(input logic [15:0] a, input logic [15:0] d, input logic w);
    wr(REG_MMD_CTRL, {11'h000, MMD_VENDOR_DEVAD});
    wr(REG_MMD_DATA, a);
    wr(REG_MMD_CTRL, {2'h1, 9'h000, MMD_VENDOR_DEVAD});
    if (w) wr(REG_MMD_DATA, d);
    else rd(REG_MMD_DATA, d);
  endtask
  task automatic indChk();
    for (int k = 0; k < 2; k++) begin
      linkUp <= k[0];
      repeat (6) @(posedge clk_sys);
      chk("ind0", s.firstInd ^ k[0], firstIndicatorOut);
      chk("ind1", s.secondInd ^ k[0], secondIndicatorOut);
    end
  endtask

  // Read results are compared in arrival order
  always @(i_psb_mdio_master.rdDone) begin
    if (expQ.size() == 0) chk("rdq", 16'h0001, 16'h0000);
    else chk("rd", expQ.pop_front(), i_psb_mdio_master.rdData);
  end

  initial begin
    repeat (80000) @(posedge clk_sys);
    n_errors++;
    wrap_up();
  end

  initial begin
    rnd = 16'($urandom(42));
    phyA = 5'h0A;
    s = {1'h0, 1'h1, 1'h1, 5'h0A, 5'h1F, 1'h0, 1'h1, 1'h0, 3'h7};
    hwrst();
    chk("mode", MAC_RMII, macMode);
    chk("ref", 16'h0001, refClockFifty);
    indChk();
    rd(REG_BASIC_CONTROL, 16'h3100);
    phyA = 5'h01;
    rd(REG_BASIC_CONTROL, 16'hFFFF);
    phyA = 5'h0A;
    ext(EXT_IND_CONFIG, IND_CONFIG_RESET, 1'h0);
    ext(EXT_MULTI_IND_CTRL, rnd, 1'h1);
    ext(EXT_MULTI_IND_CTRL, rnd, 1'h0);
    wr(REG_BASIC_CONTROL, 16'h4000);
    chk("an", 16'h0000, {anEnable, speed100, fullDuplex});
    txMii  <= {1'h1, rnd[7:4]};
    rxLine <= {1'h1, ~rnd[7:4]};
    repeat (3) @(posedge clk_sys);
    chk("loop", txMii, rxMii);
    wr(REG_BASIC_CONTROL, 16'h0080);
    chk("colOn", 16'h0001, collision);
    txMii <= '0;
    repeat (3) @(posedge clk_sys);
    chk("colOff", 16'h0000, collision);
    wr(REG_BASIC_CONTROL, 16'h2100);
    chk("force", 16'h0003, {anEnable, speed100, fullDuplex});
    wr(REG_BASIC_CONTROL, 16'h1200);
    rd(REG_BASIC_CONTROL, 16'h1000);
    wr(REG_BASIC_CONTROL, 16'h0400);
    chk("iso", 16'h0001, isolate);
    remoteFault <= 1'h1;
    @(posedge clk_sys);
    remoteFault <= 1'h0;
    rd(REG_BASIC_STATUS, 16'h7850);
    rd(REG_BASIC_STATUS, 16'h7844);
    wr(REG_BASIC_CONTROL, 16'h8000);
    rd(REG_BASIC_CONTROL, 16'h3100);
    ext(EXT_MULTI_IND_CTRL, rnd, 1'h0);
    chk("keep", MAC_RMII, macMode);
    irqPowerdownPinN <= 1'h0;
    repeat (8) @(posedge clk_sys);
    chk("pd", 16'h0001, powerDown);
    rd(REG_BASIC_CONTROL, 16'h3900);
    ext(EXT_MULTI_IND_CTRL, rnd, 1'h0);
    irqPowerdownPinN <= 1'h1;
    repeat (4) @(posedge clk_sys);
    wr(REG_BASIC_CONTROL, 16'h3100);
    chk("pdOff", 16'h0000, powerDown);
    s = {1'h1, 1'h0, 1'h0, 5'h15, 5'h00, 1'h1, 1'h0, 1'h0, 3'h5};
    phyA = 5'h01;
    hwrst();
    chk("mode2", MAC_RGMII, macMode);
    chk("ref2", 16'h0000, refClockFifty);
    indChk();
    rd(REG_BASIC_CONTROL, 16'h1100);
    wrap_up();
  end
endmodule
